// >>> aopc_pkg.sv
/*
 holds the register map, field positions, reset values and the decoded
 setting types of the output processing configuration bank.
 assumes an 8-bit register address and 8-bit register data.
*/
package aopc_pkg;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] AOPC_OFF_DECIM_FILTER = 8'h41;
   localparam logic [7:0] AOPC_OFF_ZONE = 8'h42;
   localparam logic [7:0] AOPC_OFF_CODING_SEL = 8'h43;
   localparam logic [7:0] AOPC_OFF_GAIN = 8'h44;
   localparam logic [7:0] AOPC_OFF_CODING_EN = 8'h4b;
   localparam logic [7:0] AOPC_OFF_DECIM_OVR = 8'h4d;
   localparam logic [7:0] AOPC_OFF_ZONE_EN = 8'h4e;
   localparam logic [7:0] AOPC_OFF_GAIN_EN = 8'h52;
   localparam logic [7:0] AOPC_OFF_APPLY = 8'h00;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int AOPC_POS_DECIM_HI = 4;
   localparam int AOPC_POS_DECIM_OVR = 3;
   localparam int AOPC_POS_ZONE_EN = 7;
   localparam int AOPC_POS_CODING_EN = 5;
   localparam int AOPC_POS_CODING_SEL = 0;
   localparam int AOPC_POS_GAIN_EN = 0;
   localparam int AOPC_POS_APPLY = 0;

   // ---------------------------------------------------------------
   // reset values and codes
   // ---------------------------------------------------------------
   localparam logic [2:0] AOPC_RST_DECIM_LO = 3'h2;
   localparam logic [2:0] AOPC_RST_ZONE = 3'h0;
   localparam logic [6:0] AOPC_RST_GAIN = 7'h00;
   localparam logic [3:0] AOPC_CODE_LOWPASS = 4'ha;
   localparam logic [3:0] AOPC_CODE_HIGHPASS = 4'he;
   localparam logic [2:0] AOPC_ZONE_FIRST = 3'h0;
   localparam logic [2:0] AOPC_ZONE_SECOND = 3'h1;
   localparam logic [2:0] AOPC_ZONE_THIRD = 3'h2;
   localparam logic [6:0] AOPC_GAIN_UNITY = 7'h20; // field value for 0 dB

   // filter mode as handed to the data path
   typedef enum logic [1:0] {
      AOPC_FILT_LOWPASS = 2'h0,
      AOPC_FILT_HIGHPASS = 2'h1,
      AOPC_FILT_UNSUPPORTED = 2'h2
   } aopc_filter_type;

   // settings that act on the data path after an apply pulse
   typedef struct packed {
      aopc_filter_type filter_mode;
      logic zone_valid;
      logic [1:0] zone_index;     // 0 first, 1 second, 2 third
      logic offset_binary;
      logic [6:0] gain_code;      // gain = code / 32, unity when off
   } aopc_settings_type;

   // register-side access bundle
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } aopc_bus_type;

endpackage : aopc_pkg

// >>> aopc_decode.sv
/*
 holds the decoder that turns raw register fields into the settings
 that the data path uses.
 assumes the caller registers the result on its own apply event.
*/
`timescale 1ns/10ps
`default_nettype none

module aopc_decode
   import aopc_pkg::*;
(
   input wire logic [3:0] decim_filter_code,
   input wire logic decim_override_on,
   input wire logic [2:0] zone_code,
   input wire logic zone_enable,
   input wire logic coding_select,
   input wire logic coding_enable,
   input wire logic [6:0] gain_code,
   input wire logic gain_stage_enable,
   output aopc_settings_type settings
);

   // ---------------------------------------------------------------
   // filter mode
   // ---------------------------------------------------------------
   // override off always gives low-pass with decimation by two
   wire logic code_low = (decim_filter_code == AOPC_CODE_LOWPASS);
   wire logic code_high = (decim_filter_code == AOPC_CODE_HIGHPASS);
   wire aopc_filter_type filt_sel =
      !decim_override_on ? AOPC_FILT_LOWPASS :          // [R13]
      code_low ? AOPC_FILT_LOWPASS :                     // [R2]
      code_high ? AOPC_FILT_HIGHPASS :                   // [R2]
      AOPC_FILT_UNSUPPORTED;                             // [R2]

   // ---------------------------------------------------------------
   // nyquist zone, each zone spans half the device clock
   // ---------------------------------------------------------------
   wire logic zone_known = (zone_code == AOPC_ZONE_FIRST) ||
      (zone_code == AOPC_ZONE_SECOND) || (zone_code == AOPC_ZONE_THIRD);
   wire logic zone_ok = zone_enable && zone_known;      // [R4] [R6]

   // ---------------------------------------------------------------
   // coding and gain
   // ---------------------------------------------------------------
   wire logic off_bin = coding_enable && coding_select; // [R7] [R9]
   wire logic [6:0] gain_out =
      gain_stage_enable ? gain_code : AOPC_GAIN_UNITY;  // [R10]

   assign settings.filter_mode = filt_sel;
   assign settings.zone_valid = zone_ok;
   assign settings.zone_index = zone_ok ? zone_code[1:0] : 2'h0;
   assign settings.offset_binary = off_bin;
   assign settings.gain_code = gain_out;

endmodule : aopc_decode

`default_nettype wire

// >>> aopc_regs.sv
/*
 holds the output processing configuration register bank: nine
 registers of stored fields, read-back, and the apply latch that hands
 new settings to the data path.
 assumes a single-cycle strobe master on mclk, read data in the next
 cycle, and a data path that reads the settings output.
*/
// How it works
// [R1] decimation code is bit 4 plus bits 2-0; lower field resets to 2.
// [R2] override on: 1010 low-pass, 1110 high-pass, others unsupported.
// [R3] software sets override bit 3 of 4Dh to use the code.
// [R4] zone field: 000 first, 001 second, 010 third; resets to zero.
// [R5] software sets bit 7 of 4Eh to use the programmed zone.
// [R6] zone edges are multiples of half the device clock.
// [R7] coding bit 0: twos complement at 0, offset binary at 1.
// [R8] software sets bit 5 of 4Bh to let coding select act.
// [R9] coding enable low forces twos complement; high follows select.
// [R10] seven-bit gain field, gain equals value over 32, at most 7Fh.
// [R11] software sets bit 0 of 52h to apply the gain.
// [R12] settings take effect only after a 0-1-0 pulse of apply bit.
// [R13] override low keeps the default low-pass decimate-by-two mode.
// [R14] reserved bits are written zero and ignored by the logic; bit 7 of 44h is still stored and read back.
// [R15] every register is eight bits and reads back its stored fields.
`timescale 1ns/10ps
`default_nettype none

module aopc_regs
   import aopc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output aopc_settings_type settings,
   output logic apply_done
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // address match used by the write decode and by the read mux
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic decim_hi_reg;
   logic [2:0] decim_lo_reg;
   logic [2:0] zone_reg;
   logic coding_sel_reg;
   logic [6:0] gain_reg;
   logic gain_b7_reg;
   logic coding_en_reg;
   logic decim_override_bit_reg;
   logic zone_en_reg;
   logic gain_stage_enable_reg;
   logic apply_reg;
   logic apply_prev_reg;
   logic [7:0] rdata_reg;
   aopc_settings_type live_reg;
   logic done_reg;

   aopc_bus_type bus;
   assign bus.addr = reg_addr;
   assign bus.wdata = reg_wdata;
   assign bus.wr = reg_wr;
   assign bus.rd = reg_rd;

   // ---------------------------------------------------------------
   // write decode
   // ---------------------------------------------------------------
   wire logic wr_decim = bus.wr && hit(bus.addr, AOPC_OFF_DECIM_FILTER);
   wire logic wr_zone = bus.wr && hit(bus.addr, AOPC_OFF_ZONE);
   wire logic wr_csel = bus.wr && hit(bus.addr, AOPC_OFF_CODING_SEL);
   wire logic wr_gain = bus.wr && hit(bus.addr, AOPC_OFF_GAIN);
   wire logic wr_cen = bus.wr && hit(bus.addr, AOPC_OFF_CODING_EN);
   wire logic wr_ovr = bus.wr && hit(bus.addr, AOPC_OFF_DECIM_OVR);
   wire logic wr_zen = bus.wr && hit(bus.addr, AOPC_OFF_ZONE_EN);
   wire logic wr_gen = bus.wr && hit(bus.addr, AOPC_OFF_GAIN_EN);
   wire logic wr_apply = bus.wr && hit(bus.addr, AOPC_OFF_APPLY);

   // field registers, reserved bits are not stored except bit 7 of the gain register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         decim_hi_reg <= 1'b0;
         decim_lo_reg <= AOPC_RST_DECIM_LO;            // [R1]
         zone_reg <= AOPC_RST_ZONE;                     // [R4]
         coding_sel_reg <= 1'b0;                        // [R7]
         gain_reg <= AOPC_RST_GAIN;
         gain_b7_reg <= 1'b0;
         coding_en_reg <= 1'b0;
         decim_override_bit_reg <= 1'b0;
         zone_en_reg <= 1'b0;
         gain_stage_enable_reg <= 1'b0;
         apply_reg <= 1'b0;
      end else begin
         if (wr_decim) begin
            decim_hi_reg <= bus.wdata[AOPC_POS_DECIM_HI];  // [R1]
            decim_lo_reg <= bus.wdata[2:0];                // [R1]
         end
         if (wr_zone) begin
            zone_reg <= bus.wdata[2:0];                    // [R4]
         end
         if (wr_csel) begin
            coding_sel_reg <= bus.wdata[AOPC_POS_CODING_SEL];
         end
         if (wr_gain) begin
            gain_reg <= bus.wdata[6:0];                    // [R10]
            gain_b7_reg <= bus.wdata[7];                   // [R15]
         end
         if (wr_cen) begin
            coding_en_reg <= bus.wdata[AOPC_POS_CODING_EN];
         end
         if (wr_ovr) begin
            decim_override_bit_reg <= bus.wdata[AOPC_POS_DECIM_OVR];
         end
         if (wr_zen) begin
            zone_en_reg <= bus.wdata[AOPC_POS_ZONE_EN];
         end
         if (wr_gen) begin
            gain_stage_enable_reg <= bus.wdata[AOPC_POS_GAIN_EN];
         end
         if (wr_apply) begin
            apply_reg <= bus.wdata[AOPC_POS_APPLY];
         end
      end
   end

   // ---------------------------------------------------------------
   // read mux, unmapped offsets read zero
   // ---------------------------------------------------------------
   wire logic [7:0] rd_decim = {3'h0, decim_hi_reg, 1'b0, decim_lo_reg};
   wire logic [7:0] rd_zone = {5'h00, zone_reg};
   wire logic [7:0] rd_csel = {7'h00, coding_sel_reg};
   wire logic [7:0] rd_gain = {gain_b7_reg, gain_reg};
   wire logic [7:0] rd_cen = {2'h0, coding_en_reg, 5'h00};
   wire logic [7:0] rd_ovr = {4'h0, decim_override_bit_reg, 3'h0};
   wire logic [7:0] rd_zen = {zone_en_reg, 7'h00};
   wire logic [7:0] rd_gen = {7'h00, gain_stage_enable_reg};
   wire logic [7:0] rd_apply = {7'h00, apply_reg};
   wire logic [7:0] rd_sel =
      hit(bus.addr, AOPC_OFF_DECIM_FILTER) ? rd_decim :   // [R15]
      hit(bus.addr, AOPC_OFF_ZONE) ? rd_zone :
      hit(bus.addr, AOPC_OFF_CODING_SEL) ? rd_csel :
      hit(bus.addr, AOPC_OFF_GAIN) ? rd_gain :
      hit(bus.addr, AOPC_OFF_CODING_EN) ? rd_cen :
      hit(bus.addr, AOPC_OFF_DECIM_OVR) ? rd_ovr :
      hit(bus.addr, AOPC_OFF_ZONE_EN) ? rd_zen :
      hit(bus.addr, AOPC_OFF_GAIN_EN) ? rd_gen :
      hit(bus.addr, AOPC_OFF_APPLY) ? rd_apply : 8'h00;

   // read data stands only in the cycle after the strobe
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= bus.rd ? rd_sel : 8'h00;
      end
   end
   assign reg_rdata = rdata_reg;

   // ---------------------------------------------------------------
   // decode of pending fields
   // ---------------------------------------------------------------
   aopc_settings_type pending;

   aopc_decode u_decode (
      .decim_filter_code({decim_hi_reg, decim_lo_reg}),       // [R1]
      .decim_override_on(decim_override_bit_reg),             // [R3]
      .zone_code(zone_reg),
      .zone_enable(zone_en_reg),                              // [R5]
      .coding_select(coding_sel_reg),
      .coding_enable(coding_en_reg),                          // [R8]
      .gain_code(gain_reg),
      .gain_stage_enable(gain_stage_enable_reg),              // [R11]
      .settings(pending)
   );

   // ---------------------------------------------------------------
   // apply latch
   // ---------------------------------------------------------------
   // falling edge of the apply bit ends the 0-1-0 pulse
   wire logic apply_fall = apply_prev_reg && !apply_reg;      // [R12]

   // default settings match the reset field values
   localparam aopc_settings_type AOPC_LIVE_RESET = '{
      filter_mode: AOPC_FILT_LOWPASS,
      zone_valid: 1'b0,
      zone_index: 2'h0,
      offset_binary: 1'b0,
      gain_code: AOPC_GAIN_UNITY
   };

   // live settings change only after the full pulse
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         apply_prev_reg <= 1'b0;
         live_reg <= AOPC_LIVE_RESET;
         done_reg <= 1'b0;
      end else begin
         apply_prev_reg <= apply_reg;
         done_reg <= apply_fall;
         if (apply_fall) begin
            live_reg <= pending;                              // [R12]
         end
      end
   end

   assign settings = live_reg;
   assign apply_done = done_reg;

endmodule : aopc_regs

`default_nettype wire

// >>> aopc_regs_properties.sv
/*
 checker for the output processing register bank, bound to aopc_regs.
 assumes one clock, mclk, and the asynchronous active high reset rst.
*/
`timescale 1ns/10ps
`default_nettype none

module aopc_regs_properties
   import aopc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire aopc_settings_type settings,
   input wire logic apply_done
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   // ---------------------------------------------------------------
   // decoded bus events
   // ---------------------------------------------------------------
   logic mapped;
   logic apply_set;
   logic apply_clr;
   assign mapped = reg_addr inside {8'h41, 8'h42, 8'h43, 8'h44, 8'h4b,
      8'h4d, 8'h4e, 8'h52, AOPC_OFF_APPLY};
   assign apply_set = reg_wr && reg_addr == AOPC_OFF_APPLY && reg_wdata[0];
   assign apply_clr = reg_wr && reg_addr == AOPC_OFF_APPLY && !reg_wdata[0];

   // the two steps of the apply pulse
   sequence apply_rise_s;
      apply_set;
   endsequence
   sequence apply_fall_s;
      apply_clr;
   endsequence

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   read_idle_zero_a: assert property (
      !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read cycle");
   unmapped_read_a: assert property (
      reg_rd && !mapped |=> reg_rdata == 8'h00)
      else $error("unmapped read gave nonzero data");
   gain_readback_a: assert property (
      (reg_wr && reg_addr == AOPC_OFF_GAIN) ##1
      (reg_rd && reg_addr == AOPC_OFF_GAIN) |=>
      reg_rdata == $past(reg_wdata, 2))
      else $error("gain register did not read back");
   decim_reserved_a: assert property (
      reg_rd && reg_addr == 8'h41 |=> (reg_rdata & 8'he8) == 8'h00)
      else $error("reserved bits read nonzero");
   apply_timing_a: assert property (
      apply_rise_s ##1 apply_fall_s |=> !apply_done ##1 apply_done)
      else $error("apply not taken on time");
   apply_cause_a: assert property (
      apply_done |-> $past(apply_clr, 2))
      else $error("apply pulse without falling apply bit");
   apply_single_a: assert property (
      apply_done |=> !apply_done)
      else $error("apply pulse longer than one cycle");
   settings_hold_a: assert property (
      $changed(settings) |-> apply_done)
      else $error("settings changed without apply");
   reset_settings_a: assert property (
      $fell(rst) |-> !settings.zone_valid && settings.zone_index == 2'h0 &&
      settings.gain_code == AOPC_GAIN_UNITY && !settings.offset_binary &&
      settings.filter_mode == AOPC_FILT_LOWPASS)
      else $error("bad reset settings");
endmodule : aopc_regs_properties

bind aopc_regs aopc_regs_properties chk_u (.mclk, .rst, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .settings, .apply_done);

`default_nettype wire

// >>> aopc_regs_test.sv
/*
 self-checking bench for the output processing register bank.
 assumes aopc_pkg, aopc_regs and its checker are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none

module aopc_regs_test import aopc_pkg::*;;
   logic mclk, rst, reg_wr, reg_rd, apply_done;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   aopc_settings_type settings;
   int errors, checked;
   logic [7:0] offs [8] = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h4b, 8'h4d, 8'h4e,
      8'h52};
   logic [7:0] rmask [8] = '{8'h17, 8'h07, 8'h01, 8'hff, 8'h20, 8'h08,
      8'h80, 8'h01};

   aopc_regs dut_u (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .settings, .apply_done);

   // ---------------------------------------------------------------
   // bus and report helpers
   // ---------------------------------------------------------------
   task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic close_out();
      if (errors == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
   endtask : wr

   task automatic rd(logic [7:0] a, logic [7:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      chk($sformatf("register %h", a), exp, reg_rdata);
   endtask : rd

   // 0-1-0 pulse of the apply bit, then bounded wait for the hand-over
   task automatic apply();
      int n;
      wr(AOPC_OFF_APPLY, 8'h01);
      wr(AOPC_OFF_APPLY, 8'h00);
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(negedge mclk);
      for (n = 0; n < 8 && apply_done !== 1'b1; n++)
         @(negedge mclk);
      if (n == 8) begin
         chk("apply done", 8'h01, {7'h00, apply_done});
         close_out();
      end else begin
         @(negedge mclk);
         chk("apply done one cycle", 8'h00, {7'h00, apply_done});
      end
   endtask : apply

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      @(negedge mclk);
      chk("reset filter", 8'h00, {6'h00, settings.filter_mode});
      chk("reset gain", 8'h20, {1'b0, settings.gain_code});
      chk("reset flags", 8'h00, {4'h0, settings.zone_valid,
         settings.zone_index, settings.offset_binary});
      for (int i = 0; i < 8; i++)
         rd(offs[i], (i == 0) ? 8'h02 : 8'h00);
   endtask : t_reset

   task automatic t_readback();
      for (int i = 0; i < 8; i++) begin
         wr(offs[i], 8'hff);
         rd(offs[i], rmask[i]);
      end
      wr(8'h45, 8'hff);
      rd(8'h45, 8'h00);
      chk("no apply", 8'h20, {1'b0, settings.gain_code});
      for (int i = 0; i < 8; i++)
         wr(offs[i], 8'h00);
   endtask : t_readback

   task automatic t_filter();
      logic [4:0] cs [4] = '{5'h0e, 5'h1a, 5'h1e, 5'h13};
      logic [1:0] want [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
      for (int i = 0; i < 4; i++) begin
         wr(AOPC_OFF_DECIM_OVR, {4'h0, cs[i][4], 3'h0});
         wr(AOPC_OFF_DECIM_FILTER, {3'h0, cs[i][3], 1'b0, cs[i][2:0]});
         apply();
         chk("filter", {6'h00, want[i]},
            {6'h00, settings.filter_mode});
      end
   endtask : t_filter

   task automatic t_zone();
      logic [3:0] cs [5] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'h1};
      logic [2:0] want [5] = '{3'h4, 3'h5, 3'h6, 3'h0, 3'h0};
      for (int i = 0; i < 5; i++) begin
         wr(AOPC_OFF_ZONE_EN, {cs[i][3], 7'h00});
         wr(AOPC_OFF_ZONE, {5'h00, cs[i][2:0]});
         apply();
         chk("zone", {5'h00, want[i]},
            {5'h00, settings.zone_valid, settings.zone_index});
      end
   endtask : t_zone

   task automatic t_coding_gain();
      logic [2:0] cod [3] = '{3'h2, 3'h4, 3'h7};
      logic [7:0] gin [3] = '{8'h7f, 8'hff, 8'h85};
      logic [6:0] gwant [3] = '{7'h20, 7'h7f, 7'h05};
      for (int i = 0; i < 3; i++) begin
         wr(AOPC_OFF_CODING_EN, {2'h0, cod[i][2], 5'h00});
         wr(AOPC_OFF_CODING_SEL, {7'h00, cod[i][1]});
         wr(AOPC_OFF_GAIN_EN, {7'h00, gin[i][7]});
         wr(AOPC_OFF_GAIN, {1'b0, gin[i][6:0]});
         apply();
         chk("coding", {7'h00, cod[i][0]},
            {7'h00, settings.offset_binary});
         chk("gain", {1'b0, gwant[i]}, {1'b0, settings.gain_code});
      end
   endtask : t_coding_gain

   // reset in mid-run brings back the reset fields and settings
   task automatic t_mid_reset();
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      chk("mid reset gain", 8'h20, {1'b0, settings.gain_code});
      chk("mid reset coding", 8'h00, {7'h00, settings.offset_binary});
      rd(AOPC_OFF_DECIM_FILTER, 8'h02);
      rd(AOPC_OFF_GAIN, 8'h00);
   endtask : t_mid_reset

   // ---------------------------------------------------------------
   // clock and main sequence
   // ---------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      errors = 0;
      checked = 0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_readback();
      t_filter();
      t_zone();
      t_coding_gain();
      t_mid_reset();
      close_out();
   end
endmodule : aopc_regs_test

`default_nettype wire
